// ### pkg/dsadc_pkg.sv
// package: register map, field positions and reset values of the slope converter control
package dsadc_pkg;
  // ****************************************************************
  // register map (printed offsets are not multiples of four: index)
  // ****************************************************************
  localparam logic [7:0] CONV_CTRL_IDX = 8'h18;
  localparam logic [7:0] CHOP_DIV_IDX = 8'h1a;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
  localparam logic [7:0] IRQ_CLEAR_IDX = 8'h21;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'h22;
  localparam logic [7:0] SUPPLY_CTRL_IDX = 8'h23;
  localparam int ADDR_W = 10;
  // ****************************************************************
  // converter_control fields
  // ****************************************************************
  localparam int CC_PWR_BIT = 0;
  localparam int CC_PHASE_LO = 1;
  localparam int CC_CMP_BIT = 3;
  localparam int CC_TRIG_LO = 4;
  localparam int CC_CHOP_BIT = 6;
  // ****************************************************************
  // chopper_divider_and_input fields
  // ****************************************************************
  localparam int CD_DIV_LO = 0;
  localparam int CD_REF_BIT = 4;
  localparam int CD_SRC_LO = 5;
  localparam int CD_GAIN_BIT = 7;
  // writable masks, reserved bits read zero
  localparam logic [7:0] CC_WR_MASK = 8'h77;
  localparam logic [7:0] CD_WR_MASK = 8'hf7;
  localparam logic [7:0] CC_RESET = 8'h00;
  localparam logic [7:0] CD_RESET = 8'h00;
  // ****************************************************************
  // codes
  // ****************************************************************
  localparam logic [1:0] PHASE_CHARGE = 2'h1;
  localparam logic [1:0] PHASE_DISCHARGE = 2'h2;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_THRESH = 2'h1;
  localparam logic [1:0] SRC_CHOPPER = 2'h2;
  // interrupt status bits
  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;
  // chopper prescale of the system clock, full period in cycles
  localparam int CHOP_PRESCALE = 32;
  localparam int CHOP_MAX_CODE = 4;
endpackage : dsadc_pkg

// ### src/dsadc_chopper.sv
// chopper clock divider: system clock / 32 / 2^code, stopped when idle
module dsadc_chopper #(
  parameter int PRESCALE = dsadc_pkg::CHOP_PRESCALE,
  parameter int MAX_CODE = dsadc_pkg::CHOP_MAX_CODE
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] code_i,
  // output
  output logic chop_o
);
  localparam int CNT_W = $clog2(PRESCALE << MAX_CODE) + 1;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] half_w;
  logic [2:0] code_w;

  initial begin
    if (PRESCALE < 2 || (PRESCALE % 2) != 0 || MAX_CODE > 7) begin
      $error("dsadc_chopper: unsupported prescale or code range");
    end
  end

  // codes above the top one behave as the top one
  assign code_w = (code_i > 3'(MAX_CODE)) ? 3'(MAX_CODE) : code_i;
  assign half_w = CNT_W'((PRESCALE / 2) << code_w);

  // ****************************************************************
  // divider
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= '0;
      chop_o <= 1'b0;
    end else if (cnt_q + CNT_W'(1) >= half_w) begin
      cnt_q <= '0;
      chop_o <= ~chop_o;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end
endmodule : dsadc_chopper

// ### src/dsadc_ctrl.sv
// dual slope converter control block with classic wishbone slave
// Notes on behaviour
// - control bit 0 gates converter and amplifier power from the regulator
// - phase field 01 charges from buffer, 10 discharges to reference
// - comparator level bit 3 is read only; writes leave it alone
// - during discharge comparator level falls once integrator drops below reference
// - edge trigger field: 00 none, 01 rise, 10 fall, 11 both
// - control bit 6 runs or stops the chopper clock
// - divider code 0..4 gives system clock over 32 times 1,2,4,8,16
// - divider bit 4 selects lower or higher reference pair
// - source field: 00 analog input, 01 threshold pin, 10 chopper pin
// - divider bit 7 selects amplifier gain two or four
// - divider bit 3 and control bit 7 always read zero
// - bandgap follows regulator enable, not converter power bit
// - regulator off removes converter power regardless of power bit
module dsadc_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dsadc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog front end
  input wire logic comparator_level_i,
  output logic converter_power_on_o,
  output logic bandgap_on_o,
  output logic charge_sel_o,
  output logic discharge_sel_o,
  output logic chopper_clk_o,
  output logic reference_ratio_select_o,
  output logic [1:0] pga_source_o,
  output logic amp_gain_select_o,
  // interrupt
  output logic edge_req_o,
  output logic irq_o
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] conv_ctrl_q;
  logic [7:0] chop_div_q;
  logic regulator_module_on_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic cmp_meta_q;
  logic cmp_sync_q;
  logic cmp_prev_q;
  logic chop_w;
  logic wr_w;
  logic rd_w;
  logic [7:0] idx_w;
  logic rise_w;
  logic fall_w;
  logic hit_rise_w;
  logic hit_fall_w;
  logic [1:0] clr_w;
  logic [7:0] rd_d;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction : merge

  assign idx_w = wb_adr_i[dsadc_pkg::ADDR_W-1:2];
  assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_w = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ****************************************************************
  // bus handshake: ack one cycle after request, dropped next cycle
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_ctrl_q <= dsadc_pkg::CC_RESET;
      chop_div_q <= dsadc_pkg::CD_RESET;
      regulator_module_on_q <= 1'b0;
      irq_en_q <= 2'h0;
    end else if (wr_w) begin
      case (idx_w)
        dsadc_pkg::CONV_CTRL_IDX: begin
          // comparator and bit 7 are outside the mask
          conv_ctrl_q <= merge(conv_ctrl_q, wb_dat_i[7:0],
                               dsadc_pkg::CC_WR_MASK);
        end
        dsadc_pkg::CHOP_DIV_IDX: begin
          chop_div_q <= merge(chop_div_q, wb_dat_i[7:0],
                              dsadc_pkg::CD_WR_MASK);
        end
        dsadc_pkg::IRQ_ENABLE_IDX: begin
          irq_en_q <= wb_dat_i[1:0];
        end
        dsadc_pkg::SUPPLY_CTRL_IDX: begin
          regulator_module_on_q <= wb_dat_i[0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // comparator synchroniser and edge detection
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_meta_q <= comparator_level_i;
      cmp_sync_q <= cmp_meta_q;
      cmp_prev_q <= cmp_sync_q;
    end
  end

  assign rise_w = cmp_sync_q && !cmp_prev_q;
  assign fall_w = !cmp_sync_q && cmp_prev_q;

  // trigger field selects which edges request
  always_comb begin
    hit_rise_w = 1'b0;
    hit_fall_w = 1'b0;
    case (conv_ctrl_q[dsadc_pkg::CC_TRIG_LO +: 2])
      dsadc_pkg::TRIG_RISE: hit_rise_w = rise_w;
      dsadc_pkg::TRIG_FALL: hit_fall_w = fall_w;
      dsadc_pkg::TRIG_BOTH: begin
        hit_rise_w = rise_w;
        hit_fall_w = fall_w;
      end
      default: begin
      end
    endcase
  end

  assign clr_w = (wr_w && idx_w == dsadc_pkg::IRQ_CLEAR_IDX) ?
                 wb_dat_i[1:0] : 2'h0;

  // ****************************************************************
  // interrupt status: set wins over clear
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= 2'h0;
      edge_req_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | {hit_fall_w, hit_rise_w};
      edge_req_o <= hit_rise_w || hit_fall_w;
      irq_o <= |(((irq_stat_q & ~clr_w) | {hit_fall_w, hit_rise_w})
                 & irq_en_q);
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    rd_d = 8'h00;
    case (idx_w)
      dsadc_pkg::CONV_CTRL_IDX: begin
        rd_d = conv_ctrl_q;
        rd_d[dsadc_pkg::CC_CMP_BIT] = cmp_sync_q;
      end
      dsadc_pkg::CHOP_DIV_IDX: rd_d = chop_div_q;
      dsadc_pkg::IRQ_STATUS_IDX: rd_d = {6'h00, irq_stat_q};
      dsadc_pkg::IRQ_ENABLE_IDX: rd_d = {6'h00, irq_en_q};
      dsadc_pkg::SUPPLY_CTRL_IDX: rd_d = {7'h00, regulator_module_on_q};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_w && !wb_we_i) begin
      wb_dat_o <= {24'h000000, rd_d};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // chopper clock
  // ****************************************************************
  dsadc_chopper #(
    .PRESCALE(dsadc_pkg::CHOP_PRESCALE),
    .MAX_CODE(dsadc_pkg::CHOP_MAX_CODE)
  ) u_chopper (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(conv_ctrl_q[dsadc_pkg::CC_CHOP_BIT]),
    .code_i(chop_div_q[dsadc_pkg::CD_DIV_LO +: 3]),
    .chop_o(chop_w)
  );

  // ****************************************************************
  // analog controls, all registered
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_power_on_o <= 1'b0;
      bandgap_on_o <= 1'b0;
      charge_sel_o <= 1'b0;
      discharge_sel_o <= 1'b0;
      chopper_clk_o <= 1'b0;
      reference_ratio_select_o <= 1'b0;
      pga_source_o <= dsadc_pkg::SRC_ANALOG;
      amp_gain_select_o <= 1'b0;
    end else begin
      converter_power_on_o <= conv_ctrl_q[dsadc_pkg::CC_PWR_BIT] &&
                              regulator_module_on_q;
      bandgap_on_o <= regulator_module_on_q;
      charge_sel_o <= conv_ctrl_q[dsadc_pkg::CC_PHASE_LO +: 2] ==
                      dsadc_pkg::PHASE_CHARGE;
      discharge_sel_o <= conv_ctrl_q[dsadc_pkg::CC_PHASE_LO +: 2] ==
                         dsadc_pkg::PHASE_DISCHARGE;
      chopper_clk_o <= chop_w;
      reference_ratio_select_o <= chop_div_q[dsadc_pkg::CD_REF_BIT];
      // reserved source code 11 is passed through as written
      pga_source_o <= chop_div_q[dsadc_pkg::CD_SRC_LO +: 2];
      amp_gain_select_o <= chop_div_q[dsadc_pkg::CD_GAIN_BIT];
    end
  end
endmodule : dsadc_ctrl

// ### test/dsadc_front_model.sv
// behavioural integrator and comparator standing behind the control block
module dsadc_front_model (
  // clock
  input wire logic clk_i,
  // switch controls from the block
  input wire logic power_i,
  input wire logic charge_i,
  input wire logic discharge_i,
  // comparator
  output logic level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] integ_q;
  // ****************************************************************
  // integrator ramps up on charge, down on discharge
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!power_i) begin
      integ_q <= 8'h00;
    end else if (charge_i && integ_q != 8'hff) begin
      integ_q <= integ_q + 8'h01;
    end else if (discharge_i && integ_q != 8'h00) begin
      integ_q <= integ_q - 8'h01;
    end
  end
  // comparator drops once the ramp falls below its reference
  assign level_o = integ_q > 8'h14;
endmodule : dsadc_front_model

// ### test/dsadc_ctrl_properties.sv
// concurrent checks on the ports of the converter control block
module dsadc_ctrl_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [dsadc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic comparator_level_i,
  input wire logic converter_power_on_o,
  input wire logic bandgap_on_o,
  input wire logic charge_sel_o,
  input wire logic discharge_sel_o,
  input wire logic chopper_clk_o,
  input wire logic edge_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_timing: assert property (s_req |=> s_ack)
    else $error("ack not a single cycle after request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_ctrl_bit7: assert property (
    wb_ack_o && wb_adr_i[9:2] == dsadc_pkg::CONV_CTRL_IDX |-> !wb_dat_o[7])
    else $error("control bit 7 reads one");
  a_div_bit3: assert property (
    wb_ack_o && wb_adr_i[9:2] == dsadc_pkg::CHOP_DIV_IDX |-> !wb_dat_o[3])
    else $error("divider bit 3 reads one");
  a_power_gate: assert property (converter_power_on_o |-> bandgap_on_o)
    else $error("converter powered with regulator off");
  a_phase_excl: assert property (!(charge_sel_o && discharge_sel_o))
    else $error("charge and discharge selected together");
  a_edge_cause: assert property (
    edge_req_o |-> $past(comparator_level_i, 3) != $past(comparator_level_i, 4))
    else $error("edge request without comparator change");
  a_edge_single: assert property (edge_req_o |=> !edge_req_o)
    else $error("edge request longer than one cycle");
  a_chop_low: assert property ($fell(chopper_clk_o) |=> !chopper_clk_o[*8])
    else $error("chopper low phase too short");
endmodule : dsadc_ctrl_properties
bind dsadc_ctrl dsadc_ctrl_properties i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .comparator_level_i(comparator_level_i),
  .converter_power_on_o(converter_power_on_o), .bandgap_on_o(bandgap_on_o),
  .charge_sel_o(charge_sel_o), .discharge_sel_o(discharge_sel_o),
  .chopper_clk_o(chopper_clk_o), .edge_req_o(edge_req_o));

// ### test/dsadc_ctrl_tb.sv
// self-checking bench of the slope converter control block
module dsadc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, we, ack, lvl, pwr, bgap, chg, dis, chop;
  logic ref_s, gain, ereq, irq;
  logic [1:0] src;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  int n_fail, checked, cycles, n_edge;
  dsadc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .comparator_level_i(lvl), .converter_power_on_o(pwr),
    .bandgap_on_o(bgap), .charge_sel_o(chg), .discharge_sel_o(dis),
    .chopper_clk_o(chop), .reference_ratio_select_o(ref_s),
    .pga_source_o(src), .amp_gain_select_o(gain), .edge_req_o(ereq),
    .irq_o(irq));
  dsadc_front_model i_front (.clk_i(clk_i), .power_i(pwr), .charge_i(chg),
    .discharge_i(dis), .level_o(lvl));
  // ****************************************************************
  // reporting and bus access
  // ****************************************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] idx, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
    repeat (2) @(posedge clk_i);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask : rd_chk
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [7:0] v;
    rd_chk(dsadc_pkg::CONV_CTRL_IDX, dsadc_pkg::CC_RESET);
    rd_chk(dsadc_pkg::CHOP_DIV_IDX, dsadc_pkg::CD_RESET);
    chk({31'h0, irq}, 32'h0);
    wr(dsadc_pkg::CHOP_DIV_IDX, 8'hff);
    rd_chk(dsadc_pkg::CHOP_DIV_IDX, 8'hf7);
    for (int s = 0; s < 4; s++) begin
      v = {s[0], s[1:0], s[1], 4'h0};
      wr(dsadc_pkg::CHOP_DIV_IDX, v);
      chk({28'h0, gain, src, ref_s}, {28'h0, v[7:4]});
    end
    wr(dsadc_pkg::CONV_CTRL_IDX, 8'hf8);
    rd_chk(dsadc_pkg::CONV_CTRL_IDX, 8'h70);
    rd_chk(8'h30, 8'h00);
  endtask : t_regs
  task automatic t_phase();
    for (int p = 0; p < 4; p++) begin
      wr(dsadc_pkg::CONV_CTRL_IDX, {5'h0, p[1:0], 1'b1});
      chk({29'h0, pwr, dis, chg}, {29'h0, 1'b0, p == 2, p == 1});
    end
    wr(dsadc_pkg::SUPPLY_CTRL_IDX, 8'h01);
    chk({30'h0, pwr, bgap}, 32'h3);
    wr(dsadc_pkg::CONV_CTRL_IDX, 8'h00);
    chk({30'h0, pwr, bgap}, 32'h1);
  endtask : t_phase
  task automatic t_conv();
    logic [7:0] c;
    wr(dsadc_pkg::IRQ_ENABLE_IDX, 8'h03);
    for (int m = 0; m < 4; m++) begin
      c = {2'b00, m[1:0], 4'b0011};
      n_edge = 0;
      wr(dsadc_pkg::CONV_CTRL_IDX, c);
      repeat (40) @(posedge clk_i);
      rd_chk(dsadc_pkg::CONV_CTRL_IDX, c | 8'h08);
      wr(dsadc_pkg::CONV_CTRL_IDX, c ^ 8'h06);
      repeat (40) @(posedge clk_i);
      rd_chk(dsadc_pkg::CONV_CTRL_IDX, c ^ 8'h06);
      rd_chk(dsadc_pkg::IRQ_STATUS_IDX, {6'h0, m[1:0]});
      chk({31'h0, irq}, {31'h0, m != 0});
      chk(32'(n_edge), 32'((m & 1) + (m >> 1)));
      wr(dsadc_pkg::IRQ_CLEAR_IDX, 8'h03);
      chk({31'h0, irq}, 32'h0);
    end
    wr(dsadc_pkg::CONV_CTRL_IDX, 8'h00);
  endtask : t_conv
  task automatic t_chop();
    time t0;
    for (int k = 0; k < 6; k++) begin
      wr(dsadc_pkg::CHOP_DIV_IDX, k[7:0]);
      wr(dsadc_pkg::CONV_CTRL_IDX, 8'h40);
      @(posedge chop);
      t0 = $time;
      @(posedge chop);
      chk(32'(($time - t0) / 8), 32'(32 << (k > 4 ? 4 : k)));
      wr(dsadc_pkg::CONV_CTRL_IDX, 8'h00);
      chk({31'h0, chop}, 32'h0);
    end
  endtask : t_chop
  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // counts edge request pulses seen by the bench
  always @(posedge clk_i) begin
    if (ereq === 1'b1) begin
      n_edge++;
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 10'h0;
    wdat = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_phase();
    t_conv();
    t_chop();
    conclude();
  end
endmodule : dsadc_ctrl_tb
